// ---- cco_enc.sv ----
// Encoder and gate source model feeding the compare block
module cco_enc (
  input wire logic clock_i, // Clock
  output cco_pkg::cco_cnt_s cnt_o, // Count updates
  output logic [3:0] raw_o // Raw {gate,latch,b,a}
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle lines at start
  initial begin
    cnt_o = '0;
    raw_o = 4'h0;
  end
  // One update; value scrambled after so stale data is never trusted
  task automatic step(input logic [31:0] v, input logic up,
                      input logic [1:0] ou);
    cnt_o <= '{1'b1, up, ou[1], ou[0], v};
    @(posedge clock_i);
    cnt_o <= '{1'b0, up, 1'b0, 1'b0, ~v};
    @(posedge clock_i);
  endtask : step
  // Level pulse on a raw line
  task automatic pulse(input int i, input int w);
    raw_o[i] <= 1'b1;
    repeat (w) @(posedge clock_i);
    raw_o[i] <= 1'b0;
    @(posedge clock_i);
  endtask : pulse
endmodule : cco_enc

// ---- cco_filt.sv ----
// Input frequency limiter: a level passes once stable for the minimum pulse
`include "cco_params.svh"
module cco_filt #(
  parameter int P1K = `CCO_MINP_1K_NS / `CCO_CLK_NS,
  parameter int P2K = `CCO_MINP_2K_NS / `CCO_CLK_NS,
  parameter int P5K = `CCO_MINP_5K_NS / `CCO_CLK_NS,
  parameter int P10K = `CCO_MINP_10K_NS / `CCO_CLK_NS
) (
  input wire logic clock_i, // System clock
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic [3:0] raw_i, // Raw inputs
  input wire logic [2:0] sel_i, // Frequency select
  output logic [3:0] filt_o // Filtered inputs
);
  cco_pkg::cco_filt_s s, n;

  // Round down so a pulse of exactly the minimum width still passes
  function automatic logic [16:0] thr(input logic [2:0] sel);
    case (sel)
      `CCO_FSEL_1K: thr = 17'(P1K);
      `CCO_FSEL_2K: thr = 17'(P2K);
      `CCO_FSEL_5K: thr = 17'(P5K);
      `CCO_FSEL_10K: thr = 17'(P10K);
      `CCO_FSEL_30K: thr = 17'(`CCO_MINP_30K_NS / `CCO_CLK_NS);
      `CCO_FSEL_60K: thr = 17'(`CCO_MINP_60K_NS / `CCO_CLK_NS);
      default: thr = 17'(`CCO_MINP_100K_NS / `CCO_CLK_NS);
    endcase
  endfunction : thr

  // One stability counter per input, shared frequency setting
  always_comb begin
    n = s;
    for (int i = 0; i < 4; i++) begin
      if (raw_i[i] == s.q[i]) begin
        n.cnt[i] = '0;
      end else if (s.cnt[i] + 17'h1 >= thr(sel_i)) begin
        n.q[i] = raw_i[i];
        n.cnt[i] = '0;
      end else begin
        n.cnt[i] = s.cnt[i] + 17'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign filt_o = s.q;
endmodule : cco_filt

// ---- cco_params.svh ----
// Register offsets, reset values and timing constants of the compare block
`ifndef CCO_PARAMS_SVH
`define CCO_PARAMS_SVH
`define CCO_ADDR_W 8
`define CCO_OFS_CTRL 8'h00
`define CCO_OFS_CMP 8'h04
`define CCO_OFS_HYST 8'h08
`define CCO_OFS_PDUR 8'h0c
`define CCO_OFS_STATUS 8'h10
`define CCO_OFS_COUNT 8'h14
`define CCO_CTRL_RST 32'h0000_0500
`define CCO_CMP_RST 32'h0000_0000
`define CCO_HYST_RST 8'h00
`define CCO_PDUR_RST 8'h00
`define CCO_HYST_OFF_MAX 8'h01
`define CCO_ST_CFLAG 0
`define CCO_ST_DOUT 1
`define CCO_ST_GATE 2
`define CCO_ST_EV_LSB 8
`define CCO_ST_EV_MSB 12
`define CCO_EV_GOPEN 0
`define CCO_EV_GCLOSE 1
`define CCO_EV_CMP 2
`define CCO_EV_OVF 3
`define CCO_EV_UNF 4
`define CCO_IN_A 0
`define CCO_IN_B 1
`define CCO_IN_LATCH 2
`define CCO_IN_GATE 3
`define CCO_GATE_CHANNEL 3
`define CCO_CLK_NS 4
`define CCO_MS_NS 1000000
`define CCO_MS_CYC (`CCO_MS_NS / `CCO_CLK_NS)
`define CCO_PDUR_MS_STEP 2
`define CCO_MINP_1K_NS 400000
`define CCO_MINP_2K_NS 200000
`define CCO_MINP_5K_NS 80000
`define CCO_MINP_10K_NS 40000
`define CCO_MINP_30K_NS 13000
`define CCO_MINP_60K_NS 6700
`define CCO_MINP_100K_NS 4000
`define CCO_FSEL_1K 3'h0
`define CCO_FSEL_2K 3'h1
`define CCO_FSEL_5K 3'h2
`define CCO_FSEL_10K 3'h3
`define CCO_FSEL_30K 3'h4
`define CCO_FSEL_60K 3'h5
`define CCO_FSEL_100K 3'h6
`endif

// ---- cco_pkg.sv ----
// Types shared by the compare block and its helpers
package cco_pkg;
  typedef enum logic [1:0] {
    CCO_MODE_NONE = 2'h0,
    CCO_MODE_CMP = 2'h1,
    CCO_MODE_PULSE = 2'h2,
    CCO_MODE_RSV = 2'h3
  } cco_mode_e;
  typedef enum logic [1:0] {
    CCO_DIR_NONE = 2'h0,
    CCO_DIR_UP = 2'h1,
    CCO_DIR_DOWN = 2'h2,
    CCO_DIR_RSV = 2'h3
  } cco_dir_e;
  typedef enum logic [1:0] {
    CCO_PT_IDLE = 2'b01,
    CCO_PT_RUN = 2'b10
  } cco_pt_e;
  typedef struct packed {
    logic [15:0] rsv;
    logic [4:0] ev_en;
    logic [2:0] freq;
    logic hw_gate_en;
    logic sw_gate;
    logic user_out;
    cco_dir_e dir;
    logic rel_le;
    cco_mode_e mode;
  } cco_ctrl_s;
  typedef struct packed {
    logic valid;
    logic up;
    logic ovf;
    logic unf;
    logic [31:0] value;
  } cco_cnt_s;
  typedef struct packed {
    cco_pt_e st;
    logic [17:0] pre;
    logic [8:0] ms;
    logic [8:0] tgt;
  } cco_pt_s;
  typedef struct packed {
    logic [3:0] q;
    logic [3:0][16:0] cnt;
  } cco_filt_s;
  typedef struct packed {
    cco_ctrl_s ctrl;
    logic [31:0] cmp;
    logic [7:0] hyst;
    logic [7:0] pdur;
    logic [31:0] prdata;
    logic cflag;
    logic dout;
    logic hold;
    logic armed;
    logic gate;
    logic hwg_q;
    logic [4:0] sticky;
    logic [4:0] ev;
  } cco_top_s;
endpackage : cco_pkg

// ---- cco_pulse.sv ----
// Pulse duration timer in 2 ms steps, restarted at each pulse
`include "cco_params.svh"
module cco_pulse #(
  parameter int MS_CYCLES = `CCO_MS_CYC
) (
  input wire logic clock_i, // System clock
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic start_i, // Start a pulse
  input wire logic [7:0] dur_i, // Duration in 2 ms steps
  output logic busy_o, // Pulse running
  output logic last_o // Final cycle of the pulse
);
  localparam logic [17:0] PRE_LAST = 18'(MS_CYCLES - 1);
  cco_pkg::cco_pt_s s, n;
  logic pre_wrap;

  assign pre_wrap = s.pre == PRE_LAST;
  assign busy_o = s.st == cco_pkg::CCO_PT_RUN;
  assign last_o = busy_o && pre_wrap && (s.ms == s.tgt - 9'h1);

  // Own prescaler, so the pulse length does not depend on a free tick
  always_comb begin
    n = s;
    case (s.st)
      cco_pkg::CCO_PT_IDLE: begin
        if (start_i && dur_i != 8'h0) begin
          n.st = cco_pkg::CCO_PT_RUN;
          n.tgt = 9'(dur_i * `CCO_PDUR_MS_STEP);
          n.pre = '0;
          n.ms = '0;
        end
      end
      cco_pkg::CCO_PT_RUN: begin
        if (last_o) begin
          n.st = cco_pkg::CCO_PT_IDLE;
        end else if (pre_wrap) begin
          n.pre = '0;
          n.ms = s.ms + 9'h1;
        end else begin
          n.pre = s.pre + 18'h1;
        end
      end
      default: n.st = cco_pkg::CCO_PT_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s <= '{st: cco_pkg::CCO_PT_IDLE, default: '0};
    end else begin
      s <= n;
    end
  end
endmodule : cco_pulse

// ---- cco_top.sv ----
// Compare output, status flag, input limiter and events of one counter
`include "cco_params.svh"
module cco_top #(
  parameter int CHANNEL_ID = `CCO_GATE_CHANNEL,
  parameter int MS_CYCLES = `CCO_MS_CYC,
  parameter int FILT_1K_CYC = `CCO_MINP_1K_NS / `CCO_CLK_NS,
  parameter int FILT_2K_CYC = `CCO_MINP_2K_NS / `CCO_CLK_NS,
  parameter int FILT_5K_CYC = `CCO_MINP_5K_NS / `CCO_CLK_NS,
  parameter int FILT_10K_CYC = `CCO_MINP_10K_NS / `CCO_CLK_NS
) (
  input wire logic clock_i, // System clock, 250 MHz
  input wire logic rst_n_i, // Sync reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [7:0] paddr_i, // APB byte address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error on unmapped address
  input wire cco_pkg::cco_cnt_s cnt_i, // Counter core update
  input wire logic track_a_i, // Raw track A / pulse
  input wire logic track_b_i, // Raw track B / direction
  input wire logic latch_i, // Raw latch input
  input wire logic hw_gate_i, // Raw hardware gate
  output logic [3:0] filt_o, // Limited inputs to the core
  output logic gate_open_o, // Effective gate
  output logic dout_o, // Digital output
  output logic compare_status_flag_o, // Comparator status
  output logic [4:0] event_o // One-cycle event pulses
);
  cco_pkg::cco_top_s s, n;
  logic [3:0] raw;
  logic pt_start;
  logic pt_busy;
  logic pt_last;
  logic setup;
  logic wr;
  logic mapped;

  // Signed 33-bit view keeps compare arithmetic free of wrap-around
  function automatic logic signed [32:0] sx(input logic [31:0] v);
    sx = signed'({v[31], v});
  endfunction : sx

  // Edge of the hysteresis band around the compare value
  function automatic logic signed [32:0] band(input logic [31:0] c,
                                              input logic [7:0] h,
                                              input logic hi);
    logic signed [32:0] d;
    d = (h > `CCO_HYST_OFF_MAX) ? signed'({25'h0, h}) : '0;
    band = hi ? sx(c) + d : sx(c) - d;
  endfunction : band

  // Address decode of the register window
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      `CCO_OFS_CTRL, `CCO_OFS_CMP, `CCO_OFS_HYST, `CCO_OFS_PDUR,
      `CCO_OFS_STATUS, `CCO_OFS_COUNT: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  assign raw = {hw_gate_i, latch_i, track_b_i, track_a_i};

  // Limiter on the four counter inputs
  cco_filt #(
    .P1K(FILT_1K_CYC),
    .P2K(FILT_2K_CYC),
    .P5K(FILT_5K_CYC),
    .P10K(FILT_10K_CYC)
  ) u_filt (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .raw_i(raw),
    .sel_i(s.ctrl.freq),
    .filt_o(filt_o)
  );

  // Pulse length timer
  cco_pulse #(
    .MS_CYCLES(MS_CYCLES)
  ) u_pulse (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .start_i(pt_start),
    .dur_i(s.pdur),
    .busy_o(pt_busy),
    .last_o(pt_last)
  );

  // APB phases; the slave never inserts wait states
  assign setup = psel_i && !penable_i;
  assign wr = psel_i && penable_i && pwrite_i;
  assign mapped = is_mapped(paddr_i);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // Next state of registers, comparison and events
  always_comb begin
    logic signed [32:0] cv;
    logic signed [32:0] lo;
    logic signed [32:0] hi;
    logic eq;
    logic outside;
    logic dir_ok;
    logic set_c;
    logic clr_c;
    logic fire;
    logic hwg;
    logic ch3;
    logic [4:0] ev;
    logic [4:0] w1c;
    cv = sx(cnt_i.value);
    lo = band(s.cmp, s.hyst, 1'b0);
    hi = band(s.cmp, s.hyst, 1'b1);
    eq = cnt_i.value == s.cmp;
    outside = (cv < lo) || (cv > hi);
    dir_ok = 1'b0;
    set_c = 1'b0;
    clr_c = 1'b0;
    fire = 1'b0;
    hwg = filt_o[`CCO_IN_GATE];
    ch3 = CHANNEL_ID == `CCO_GATE_CHANNEL;
    ev = '0;
    w1c = '0;
    n = s;
    pt_start = 1'b0;

    // Register writes take effect in the access phase
    if (wr) begin
      case (paddr_i)
        `CCO_OFS_CTRL: n.ctrl = cco_pkg::cco_ctrl_s'(pwdata_i);
        `CCO_OFS_CMP: n.cmp = pwdata_i;
        `CCO_OFS_HYST: n.hyst = pwdata_i[7:0];
        `CCO_OFS_PDUR: n.pdur = pwdata_i[7:0];
        `CCO_OFS_STATUS: w1c = pwdata_i[`CCO_ST_EV_MSB:`CCO_ST_EV_LSB];
        default: n.cmp = s.cmp;
      endcase
    end

    // Read data is captured in setup so prdata_o comes from a flop
    if (setup && !pwrite_i) begin
      case (paddr_i)
        `CCO_OFS_CTRL: n.prdata = s.ctrl;
        `CCO_OFS_CMP: n.prdata = s.cmp;
        `CCO_OFS_HYST: n.prdata = {24'h0, s.hyst};
        `CCO_OFS_PDUR: n.prdata = {24'h0, s.pdur};
        `CCO_OFS_STATUS: begin
          n.prdata = '0;
          n.prdata[`CCO_ST_CFLAG] = s.cflag;
          n.prdata[`CCO_ST_DOUT] = s.dout;
          n.prdata[`CCO_ST_GATE] = s.gate;
          n.prdata[`CCO_ST_EV_MSB:`CCO_ST_EV_LSB] = s.sticky;
        end
        `CCO_OFS_COUNT: n.prdata = cnt_i.value;
        default: n.prdata = '0;
      endcase
    end

    // Main direction filter for pulse arrivals
    case (s.ctrl.dir)
      cco_pkg::CCO_DIR_UP: dir_ok = cnt_i.up;
      cco_pkg::CCO_DIR_DOWN: dir_ok = !cnt_i.up;
      default: dir_ok = 1'b1;
    endcase

    // Comparator relation; clearing waits for the band edge
    if (s.ctrl.rel_le) begin
      set_c = cv <= sx(s.cmp);
      clr_c = cv > hi;
    end else begin
      set_c = cv >= sx(s.cmp);
      clr_c = cv < lo;
    end

    // Output characteristic; in compare mode the flag changes only on a counter update
    case (s.ctrl.mode)
      cco_pkg::CCO_MODE_CMP: begin
        n.hold = 1'b0;
        n.armed = 1'b1;
        if (cnt_i.valid) begin
          if (set_c) begin
            n.cflag = 1'b1;
          end else if (clr_c) begin
            n.cflag = 1'b0;
          end
        end
        n.dout = n.cflag;
        ev[`CCO_EV_CMP] = n.cflag && !s.cflag;
      end
      cco_pkg::CCO_MODE_PULSE: begin
        // Busy and hold block any retrigger while the output is high
        fire = cnt_i.valid && eq && s.armed && dir_ok && !pt_busy &&
               !s.hold;
        if (fire) begin
          n.armed = 1'b0;
        end else if (cnt_i.valid && outside) begin
          n.armed = 1'b1;
        end
        pt_start = fire && s.pdur != `CCO_PDUR_RST;
        if (fire && s.pdur == `CCO_PDUR_RST) begin
          n.hold = 1'b1;
        end else if (cnt_i.valid && !eq) begin
          n.hold = 1'b0;
        end
        // Output drops in the cycle the timer goes idle
        n.dout = pt_start || (pt_busy && !pt_last) || n.hold;
        n.cflag = n.dout;
        ev[`CCO_EV_CMP] = fire;
      end
      default: begin
        n.dout = s.ctrl.user_out;
        n.cflag = 1'b0;
        n.hold = 1'b0;
        n.armed = 1'b1;
      end
    endcase

    // Effective gate; hardware gate only counts on the gate channel
    n.gate = s.ctrl.sw_gate && (!(ch3 && s.ctrl.hw_gate_en) || hwg);
    n.hwg_q = hwg;
    if (ch3 && s.ctrl.sw_gate) begin
      ev[`CCO_EV_GOPEN] = hwg && !s.hwg_q;
      ev[`CCO_EV_GCLOSE] = !hwg && s.hwg_q;
    end
    ev[`CCO_EV_OVF] = cnt_i.ovf;
    ev[`CCO_EV_UNF] = cnt_i.unf;

    // Enables gate the events; a new event wins over a clear
    n.ev = ev & s.ctrl.ev_en;
    n.sticky = (s.sticky & ~w1c) | n.ev;
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.ctrl <= cco_pkg::cco_ctrl_s'(`CCO_CTRL_RST);
      s.cmp <= `CCO_CMP_RST;
      s.hyst <= `CCO_HYST_RST;
      s.pdur <= `CCO_PDUR_RST;
      s.armed <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign prdata_o = s.prdata;
  assign gate_open_o = s.gate;
  assign dout_o = s.dout;
  assign compare_status_flag_o = s.cflag;
  assign event_o = s.ev;
endmodule : cco_top

// ---- cco_top_asserts.sv ----
// Port checker for the compare block, bound into its top
`include "cco_params.svh"
module cco_top_asserts #(
  parameter int MS_CYCLES = 10
) (
  input wire logic clock_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB write
  input wire logic [7:0] paddr_i, // APB address
  input wire logic [31:0] pwdata_i, // APB data
  input wire cco_pkg::cco_cnt_s cnt_i, // Count update
  input wire logic [3:0] filt_o, // Limited inputs
  input wire logic gate_open_o, // Gate
  input wire logic dout_o, // Output
  input wire logic compare_status_flag_o, // Flag
  input wire logic [4:0] event_o // Events
);
  cco_pkg::cco_ctrl_s c_reg;
  logic [31:0] cmp_reg;
  logic [7:0] pd_reg, pd_q, pd_lat;
  logic q_reg, wr, pulse, rel_ok, dir_ok;
  int hi_reg;
  // Decoded helpers
  assign wr = psel_i && penable_i && pwrite_i;
  assign pulse = c_reg.mode == cco_pkg::CCO_MODE_PULSE;
  assign rel_ok = c_reg.rel_le ? $signed(cnt_i.value) <= $signed(cmp_reg)
    : $signed(cnt_i.value) >= $signed(cmp_reg);
  assign dir_ok = (c_reg.dir != cco_pkg::CCO_DIR_UP || cnt_i.up) &&
    (c_reg.dir != cco_pkg::CCO_DIR_DOWN || !cnt_i.up);
  // Settings shadow; length judged on the duration seen at fire
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      c_reg <= `CCO_CTRL_RST;
      cmp_reg <= `CCO_CMP_RST;
      pd_reg <= `CCO_PDUR_RST;
      pd_q <= 8'h00;
      pd_lat <= 8'h00;
      q_reg <= 1'b0;
      hi_reg <= 0;
    end else begin
      if (wr && paddr_i == `CCO_OFS_CTRL) c_reg <= pwdata_i;
      if (wr && paddr_i == `CCO_OFS_CMP) cmp_reg <= pwdata_i;
      if (wr && paddr_i == `CCO_OFS_PDUR) pd_reg <= pwdata_i[7:0];
      pd_q <= pd_reg;
      q_reg <= dout_o;
      if (dout_o && !q_reg) pd_lat <= pd_q;
      hi_reg <= dout_o ? hi_reg + 1 : 0;
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence rise_s;
    !dout_o && pulse ##1 dout_o;
  endsequence
  none_mode_a: assert property (
    c_reg.mode == cco_pkg::CCO_MODE_NONE |=>
    !compare_status_flag_o && dout_o == $past(c_reg.user_out))
    else $error("plain mode output wrong");
  cmp_set_a: assert property (
    c_reg.mode == cco_pkg::CCO_MODE_CMP && cnt_i.valid && rel_ok
    |=> dout_o && compare_status_flag_o)
    else $error("comparator did not set");
  fire_cause_a: assert property (
    rise_s |-> $past(cnt_i.valid && cnt_i.value == cmp_reg && dir_ok))
    else $error("pulse without matching arrival");
  pulse_len_a: assert property (
    $fell(dout_o) && pulse && pd_lat != 0 |->
    hi_reg == 2 * MS_CYCLES * pd_lat)
    else $error("pulse length wrong");
  zero_hold_a: assert property (
    pulse && pd_lat == 0 && q_reg && dout_o && cnt_i.valid &&
    cnt_i.value != cmp_reg |=> !dout_o)
    else $error("zero duration output not released");
  cmp_event_a: assert property (
    $rose(compare_status_flag_o) && $past(c_reg.mode) ==
    cco_pkg::CCO_MODE_CMP |-> event_o[2] == $past(c_reg.ev_en[2]))
    else $error("compare event wrong");
  ev_single_a: assert property (
    event_o[2] |=> !event_o[2])
    else $error("compare event longer than a cycle");
  wrap_ev_a: assert property (
    cnt_i.valid |=> event_o[4:3] ==
    $past({cnt_i.unf, cnt_i.ovf} & c_reg.ev_en[4:3]))
    else $error("wrap event wrong");
  gate_rise_a: assert property (
    event_o[0] |-> $past(c_reg.sw_gate && c_reg.ev_en[0] && filt_o[3]))
    else $error("gate open event wrong");
  gate_fall_a: assert property (
    event_o[1] |-> $past(c_reg.sw_gate && c_reg.ev_en[1] && !filt_o[3]))
    else $error("gate close event wrong");
  gate_open_a: assert property (
    1'b1 |-> gate_open_o ==
    $past(c_reg.sw_gate && (!c_reg.hw_gate_en || filt_o[3])))
    else $error("gate level wrong");
endmodule : cco_top_asserts

bind cco_top cco_top_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .cnt_i, .filt_o, .gate_open_o, .dout_o,
  .compare_status_flag_o, .event_o);

// ---- tb.sv ----
// Self-checking bench for the compare block
`include "cco_params.svh"
`define CHK(n, x, g) begin n_compared++; if ((g) !== (x)) begin \
  bad_count++; $display("[ERR] %s exp %0h got %0h", n, x, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, seen = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, prd, r;
  logic prdy, perr, e, dout, flag, gopen;
  logic [3:0] raw, filt;
  logic [4:0] ev;
  logic [15:0] hi;
  cco_pkg::cco_cnt_s cnt;
  int bad_count = 0;
  int n_compared = 0;
  int thr[7] = '{40, 30, 20, 12, 3250, 1675, 1000};
  // Clock
  always #2 clock_i = ~clock_i;
  // Records any pass of track A through the limiter
  always @(posedge clock_i) if (filt[0]) seen <= 1'b1;
  cco_top #(.MS_CYCLES(10), .FILT_1K_CYC(40), .FILT_2K_CYC(30),
    .FILT_5K_CYC(20), .FILT_10K_CYC(12)) dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .cnt_i(cnt),
    .track_a_i(raw[0]), .track_b_i(raw[1]), .latch_i(raw[2]),
    .hw_gate_i(raw[3]), .filt_o(filt), .gate_open_o(gopen),
    .dout_o(dout), .compare_status_flag_o(flag), .event_o(ev));
  cco_enc u_enc (.clock_i(clock_i), .cnt_o(cnt), .raw_o(raw));
  // APB transfer, held until ready, then two idle edges for settling
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clock_i);
    pen <= 1'b1;
    do @(posedge clock_i); while (prdy !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input string n, input logic [7:0] a,
                     input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(n, x, r)
  endtask : rdc
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick
  // Update then look at the output level
  task automatic sd(input logic [31:0] v, input logic up, input logic x);
    u_enc.step(v, up, 2'b00);
    `CHK("dout", x, dout)
    `CHK("flag", x, flag)
  endtask : sd
  // Length of the running pulse in cycles
  task automatic meas();
    hi = 16'h0;
    while (dout === 1'b1 && hi < 16'h4000) begin
      hi++;
      @(posedge clock_i);
    end
  endtask : meas
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // Watchdog sized well above the sequence length
  initial begin
    repeat (60000) @(posedge clock_i);
    bad_count++;
    stop_test();
  end
  initial begin
    tick(20);
    rst_n_i <= 1'b1;
    rdc("ctrl", `CCO_OFS_CTRL, `CCO_CTRL_RST);
    rdc("pdur", `CCO_OFS_PDUR, 32'h0);
    rdc("stat", `CCO_OFS_STATUS, 32'h0);
    apb(1'b1, 8'h18, 32'hffff_ffff);
    `CHK("slverr", 1'b1, e)
    rdc("hole", 8'h18, 32'h0);
    wr(`CCO_OFS_CTRL, 32'h0520);
    `CHK("user", 1'b1, dout)
    // Comparator both relations, event and clearing
    wr(`CCO_OFS_CMP, 32'ha);
    wr(`CCO_OFS_CTRL, 32'h2501);
    sd(32'h9, 1'b1, 1'b0);
    sd(32'ha, 1'b1, 1'b1);
    rdc("ge", `CCO_OFS_STATUS, 32'h403);
    wr(`CCO_OFS_STATUS, 32'h1f00);
    rdc("clr", `CCO_OFS_STATUS, 32'h3);
    wr(`CCO_OFS_CTRL, 32'h2505);
    sd(32'hb, 1'b1, 1'b0);
    sd(32'hffff_fffd, 1'b0, 1'b1);
    // Hysteresis of three, then one which is off
    wr(`CCO_OFS_CTRL, 32'h2501);
    wr(`CCO_OFS_HYST, 32'h3);
    sd(32'h5, 1'b1, 1'b0);
    sd(32'ha, 1'b1, 1'b1);
    sd(32'h8, 1'b0, 1'b1);
    sd(32'h6, 1'b0, 1'b0);
    wr(`CCO_OFS_HYST, 32'h1);
    sd(32'ha, 1'b1, 1'b1);
    sd(32'h9, 1'b0, 1'b0);
    wr(`CCO_OFS_HYST, 32'h0);
    // Pulse, re-reach while running, duration change while running
    wr(`CCO_OFS_CTRL, 32'h2502);
    wr(`CCO_OFS_PDUR, 32'h2);
    u_enc.step(32'h5, 1'b1, 2'b00);
    u_enc.step(32'ha, 1'b1, 2'b00);
    fork
      meas();
      begin
        u_enc.step(32'h9, 1'b0, 2'b00);
        u_enc.step(32'ha, 1'b1, 2'b00);
        wr(`CCO_OFS_PDUR, 32'h1);
      end
    join
    `CHK("len2", 16'd40, hi)
    u_enc.step(32'h5, 1'b1, 2'b00);
    u_enc.step(32'ha, 1'b1, 2'b00);
    meas();
    `CHK("len1", 16'd20, hi)
    // Main direction up
    wr(`CCO_OFS_CTRL, 32'h250a);
    sd(32'h5, 1'b1, 1'b0);
    sd(32'ha, 1'b0, 1'b0);
    sd(32'hb, 1'b0, 1'b0);
    sd(32'ha, 1'b1, 1'b1);
    tick(25);
    // Main direction down: an arrival while counting up is ignored
    wr(`CCO_OFS_CTRL, 32'h2512);
    sd(32'h5, 1'b1, 1'b0);
    sd(32'ha, 1'b1, 1'b0);
    sd(32'hb, 1'b0, 1'b0);
    sd(32'ha, 1'b0, 1'b1);
    tick(25);
    // Duration zero holds while matched
    wr(`CCO_OFS_PDUR, 32'h0);
    wr(`CCO_OFS_CTRL, 32'h2502);
    sd(32'h5, 1'b1, 1'b0);
    sd(32'ha, 1'b1, 1'b1);
    sd(32'ha, 1'b1, 1'b1);
    sd(32'hb, 1'b1, 1'b0);
    // Wrap events, one enabled at a time
    wr(`CCO_OFS_CTRL, 32'h4500);
    wr(`CCO_OFS_STATUS, 32'h1f00);
    u_enc.step(32'h0, 1'b1, 2'b10);
    u_enc.step(32'h0, 1'b0, 2'b01);
    rdc("ovf", `CCO_OFS_STATUS, 32'h800);
    wr(`CCO_OFS_CTRL, 32'h8500);
    u_enc.step(32'h0, 1'b0, 2'b01);
    rdc("unf", `CCO_OFS_STATUS, 32'h1800);
    // Gate edges at 10 kHz limit
    wr(`CCO_OFS_CTRL, 32'h1bc0);
    wr(`CCO_OFS_STATUS, 32'h1f00);
    rdc("hwg", `CCO_OFS_STATUS, 32'h0);
    u_enc.pulse(3, 30);
    tick(20);
    rdc("gev", `CCO_OFS_STATUS, 32'h300);
    wr(`CCO_OFS_CTRL, 32'h1b40);
    rdc("swg", `CCO_OFS_STATUS, 32'h304);
    `CHK("gopen", 1'b1, gopen)
    wr(`CCO_OFS_CTRL, 32'h1b80);
    wr(`CCO_OFS_STATUS, 32'h1f00);
    u_enc.pulse(3, 30);
    tick(20);
    rdc("gshut", `CCO_OFS_STATUS, 32'h0);
    // Limiter: half width refused, width above limit passed
    foreach (thr[i]) begin
      wr(`CCO_OFS_CTRL, 32'(i) << 8);
      seen = 1'b0;
      u_enc.pulse(0, thr[i] / 2);
      tick(thr[i] + 5);
      `CHK("short", 1'b0, seen)
      u_enc.pulse(0, thr[i] + 4);
      tick(thr[i] + 5);
      `CHK("long", 1'b1, seen)
    end
    stop_test();
  end
endmodule : tb
